// ### logic/fps_pkg.sv
// Shared constants, enumerations and carrier types of the flash sequencer.
package fps_pkg;

	// Command codes held in the upper byte of command object word 0.
	localparam logic [7:0]  FPS_CMD_PROG  = 8'h06;
	localparam logic [7:0]  FPS_CMD_OTP   = 8'h07;
	localparam logic [7:0]  FPS_CMD_ERALL = 8'h08;
	localparam logic [7:0]  FPS_CMD_ERBLK = 8'h09;

	// Field positions inside command object word 0.
	localparam int          FPS_CODE_MSB  = 15;
	localparam int          FPS_CODE_LSB  = 8;

	// Command word index that each command expects at launch.
	localparam logic [2:0]  FPS_IX_LAST   = 3'h5;
	localparam logic [2:0]  FPS_IX_ERALL  = 3'h0;
	localparam logic [2:0]  FPS_IX_ERBLK  = 3'h1;
	localparam int          FPS_NWORDS    = 6;

	// Block selection values of global address bits 17:16.
	localparam logic [1:0]  FPS_SEL_PF    = 2'h3;
	localparam logic [1:0]  FPS_SEL_EE    = 2'h0;

	// Highest one-time phrase index.
	localparam logic [15:0] FPS_OTP_MAX   = 16'h0007;

	// Read-back value of an erased or unwritten phrase.
	localparam logic [63:0] FPS_ERASED    = 64'hFFFF_FFFF_FFFF_FFFF;

	// Bit positions of the per-command mode permission input.
	localparam int          FPS_MB_PROG   = 0;
	localparam int          FPS_MB_OTP    = 1;
	localparam int          FPS_MB_ERALL  = 2;
	localparam int          FPS_MB_ERBLK  = 3;

	// Bit positions of the error flag clear input.
	localparam int          FPS_CB_ACC    = 0;
	localparam int          FPS_CB_PV     = 1;

	// High-voltage pulse times and their cycle counts at the clock rate.
	localparam int          FPS_CLK_MHZ   = 100;
	localparam int          FPS_PROG_US   = 20;
	localparam int          FPS_ERASE_MS  = 20;
	localparam int          FPS_PROG_CYCLES  = FPS_PROG_US * FPS_CLK_MHZ;
	localparam int          FPS_ERASE_CYCLES =
		FPS_ERASE_MS * 1000 * FPS_CLK_MHZ;
	localparam int          FPS_TW        = 22;

	// Operations offered to the flash array.
	typedef enum logic [3:0] {
		FPS_OP_NONE,
		FPS_OP_READ,
		FPS_OP_PROG,
		FPS_OP_OTP_READ,
		FPS_OP_OTP_PROG,
		FPS_OP_ERASE_BLK,
		FPS_OP_ERASE_ALL,
		FPS_OP_BLANK_BLK,
		FPS_OP_BLANK_ALL
	} fps_op_t;

	// Request to the array; valid is a one-cycle pulse.
	typedef struct packed {
		logic        valid;
		fps_op_t     op;
		logic [17:0] addr;
		logic [63:0] wdata;
	} fps_arr_cmd_t;

	// Answer of the array to a read or blank check.
	typedef struct packed {
		logic        valid;
		logic [63:0] rdata;
		logic        ecc_err;
		logic        ecc_uncorr;
	} fps_arr_rsp_t;

	// Status flags seen by software.
	typedef struct packed {
		logic command_complete_flag;
		logic access_error_flag;
		logic protection_violation_flag;
		logic verify_error_flag;
		logic verify_uncorrectable_flag;
	} fps_status_t;

endpackage

// ### logic/fps_pulse_timer.sv
// Down-counter that times one high-voltage program or erase pulse.
`timescale 1ns/1ps
module fps_pulse_timer
	import fps_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic [FPS_TW-1:0] load,
	output logic                   busy,
	output logic                   done
);

	logic [FPS_TW-1:0] count;      // Cycles left in the pulse.
	logic [FPS_TW-1:0] next_count; // Next value of the counter.
	logic              next_busy;  // Next value of the busy level.
	logic              next_done;  // Next value of the done pulse.

	// A start reloads the counter; the last count raises done for a cycle.
	always_comb begin
		next_count = count;
		next_busy  = busy;
		next_done  = 1'b0;
		if (start) begin
			next_count = load;
			next_busy  = 1'b1;
		end else if (busy) begin
			if (count <= FPS_TW'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_count = count - FPS_TW'(1);
			end
		end
	end

	// Registers of the timer.
	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			busy  <= next_busy;
			done  <= next_done;
		end
	end

endmodule

// ### logic/fps_sequencer.sv
// Program and erase command sequencer of the embedded flash module.
// Overview of operation
// - Code 0x06 in word 0 with block bits.
// - Word 1 phrase address, words 2-5 data.
// - Phrase address bits 2:0 nonzero: access error.
// - Program commands need index 101 at launch.
// - Launch programs, verifies, then sets complete flag.
// - Protected program address sets protection violation.
// - Verify errors set the verify error flag; uncorrectable ones set both verify flags.
// - Command not allowed in mode: access error.
// - Code 0x07, phrase index 0-7, four words.
// - One-time program: blank check, program, verify.
// - One-time index above seven: access error.
// - Already written one-time phrase: access error.
// - All-ones one-time phrase counts as unwritten.
// - Program flash reads invalid during one-time program.
// - Code 0x08 needs index 000 at launch.
// - Erase all, verify, release security if blank.
// - Any protection blocks erase all: protection violation.
// - Code 0x09, address in words 0-1, index 001.
// - Invalid block selection: access error.
// - Misaligned block erase address: access error.
// - Protected block: violation, else erase and verify.
// - Program address outside program flash: access error.
`timescale 1ns/1ps
module fps_sequencer
	import fps_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES = FPS_ERASE_CYCLES
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         cmd_wr,
	input  wire logic [15:0]  cmd_wdata,
	input  wire logic [2:0]   command_word_index,
	input  wire logic         launch,
	input  wire logic [1:0]   err_clear,
	input  wire logic [3:0]   mode_allowed,
	input  wire logic         prot_pf_en,
	input  wire logic [17:0]  prot_pf_base,
	input  wire logic [17:0]  prot_pf_limit,
	input  wire logic         prot_ee_en,
	input  wire fps_arr_rsp_t arr_rsp,
	output fps_arr_cmd_t      arr_cmd,
	output logic              arr_hv_en,
	output logic              pflash_read_invalid,
	output logic              security_released,
	output fps_status_t       flash_status_register
);

	// Sequencer states.
	typedef enum logic [2:0] {
		FPS_IDLE, FPS_CHECK, FPS_PRE, FPS_HV, FPS_VWAIT, FPS_DONE
	} fps_state_t;

	logic [FPS_NWORDS-1:0][15:0] cmd_word; // Command object words.
	logic              wr_ok;      // Word write accepted this cycle.
	logic              launch_ok;  // Launch accepted this cycle.
	fps_state_t        state;      // Current sequencer state.
	fps_state_t        next_state; // Next sequencer state.
	fps_status_t       st;         // Status flags.
	fps_status_t       next_st;    // Next status flags.
	logic [2:0]        idx;        // Word index sampled at launch.
	logic [2:0]        next_idx;   // Next sampled index.
	fps_arr_cmd_t      next_cmd;   // Next array request.
	logic              next_hv;    // Next high-voltage enable.
	logic              next_sec;   // Next security release level.
	logic              next_tmr;   // Starts the pulse timer this cycle.
	logic [FPS_TW-1:0] next_load;  // Pulse length handed to the timer.
	logic              tmr_done;   // Pulse has ended.
	logic [7:0]        code;       // Command code.
	logic [1:0]        sel;        // Global address bits 17:16.
	logic [17:0]       gaddr;      // Full global address.
	logic [63:0]       pdata;      // Phrase data, word 2 lowest.
	logic [63:0]       expect_d;   // Data expected at verify.
	logic              is_prog;    // Phrase program command.
	logic              is_otp;     // One-time program command.
	logic              is_erall;   // Erase everything command.
	logic              is_erblk;   // Block erase command.
	logic              in_prot;    // Address inside protected range.
	logic              acc_err;    // Launch check found an access error.
	logic              pv_err;     // Launch check found a violation.

	// Words are taken only while idle, so a running command keeps its
	// parameters even if software ignores the no-write period.
	assign wr_ok     = cmd_wr && st.command_complete_flag;
	// Launch is refused while complete is low or the access error or protection violation flag stands.
	assign launch_ok = launch && st.command_complete_flag
		&& !st.access_error_flag && !st.protection_violation_flag;

	// One storage word per index of the command object.
	for (genvar gi = 0; gi < FPS_NWORDS; gi++) begin : g_word
		logic [15:0] next_word; // Next value of this word.
		// The addressed word follows the write data.
		always_comb begin
			next_word = cmd_word[gi];
			if (wr_ok && command_word_index == 3'(gi)) begin
				next_word = cmd_wdata;
			end
		end
		// Word register.
		always_ff @(posedge mclk) begin
			if (rst) begin
				cmd_word[gi] <= 16'h0000;
			end else begin
				cmd_word[gi] <= next_word;
			end
		end
	end

	// Decode of the stored command object.
	assign code     = cmd_word[0][FPS_CODE_MSB:FPS_CODE_LSB];
	assign sel      = cmd_word[0][1:0];
	assign gaddr    = {sel, cmd_word[1]};
	assign pdata    = {cmd_word[5], cmd_word[4], cmd_word[3], cmd_word[2]};
	assign is_prog  = (code == FPS_CMD_PROG);
	assign is_otp   = (code == FPS_CMD_OTP);
	assign is_erall = (code == FPS_CMD_ERALL);
	assign is_erblk = (code == FPS_CMD_ERBLK);
	assign in_prot  = prot_pf_en && gaddr >= prot_pf_base
		&& gaddr <= prot_pf_limit;
	assign expect_d = (is_erall || is_erblk) ? FPS_ERASED : pdata;

	// Launch checks; an unknown code is an access error.
	always_comb begin
		acc_err = 1'b1;
		pv_err  = 1'b0;
		if (is_prog) begin
			acc_err = idx != FPS_IX_LAST
				|| !mode_allowed[FPS_MB_PROG]
				|| sel != FPS_SEL_PF
				|| gaddr[2:0] != 3'h0;
			pv_err  = in_prot;
		end else if (is_otp) begin
			acc_err = idx != FPS_IX_LAST
				|| !mode_allowed[FPS_MB_OTP]
				|| cmd_word[1] > FPS_OTP_MAX;
		end else if (is_erall) begin
			acc_err = idx != FPS_IX_ERALL
				|| !mode_allowed[FPS_MB_ERALL];
			pv_err  = prot_pf_en || prot_ee_en;
		end else if (is_erblk) begin
			acc_err = idx != FPS_IX_ERBLK
				|| !mode_allowed[FPS_MB_ERBLK]
				|| (sel != FPS_SEL_PF && sel != FPS_SEL_EE)
				|| (sel == FPS_SEL_PF && gaddr[2:0] != 3'h0)
				|| (sel == FPS_SEL_EE && gaddr[0]);
			pv_err  = (sel == FPS_SEL_PF) ? prot_pf_en : prot_ee_en;
		end
	end

	// Sequencer: launch, check, optional blank check, pulse, verify.
	always_comb begin
		next_state      = state;
		next_st         = st;
		next_idx        = idx;
		next_cmd        = arr_cmd;
		next_cmd.valid  = 1'b0;
		next_hv         = arr_hv_en;
		next_sec        = security_released;
		next_tmr        = 1'b0;
		next_load       = FPS_TW'(FPS_PROG_CYCLES); // Program pulse.
		// Software clears of the error flags; a set below wins.
		next_st.access_error_flag &= !err_clear[FPS_CB_ACC];
		next_st.protection_violation_flag &= !err_clear[FPS_CB_PV];
		case (state)
			FPS_IDLE: begin
				// Clearing the complete flag starts a command.
				if (launch_ok) begin
					next_st.command_complete_flag     = 1'b0;
					next_st.verify_error_flag         = 1'b0;
					next_st.verify_uncorrectable_flag = 1'b0;
					next_idx   = command_word_index;
					next_state = FPS_CHECK;
				end
			end
			FPS_CHECK: begin
				next_cmd.addr  = gaddr;
				next_cmd.wdata = pdata;
				if (acc_err) begin
					// Rejected: no array action, complete next.
					next_st.access_error_flag = 1'b1;
					next_state = FPS_DONE;
				end else if (pv_err) begin
					next_st.protection_violation_flag = 1'b1;
					next_state = FPS_DONE;
				end else if (is_otp) begin
					// Blank check of the chosen phrase first.
					next_cmd.valid = 1'b1;
					next_cmd.op    = FPS_OP_OTP_READ;
					next_cmd.addr  = 18'(cmd_word[1]);
					next_state     = FPS_PRE;
				end else begin
					next_cmd.valid = 1'b1;
					next_hv        = 1'b1;
					next_tmr       = 1'b1;
					next_state     = FPS_HV;
					if (is_prog) begin
						next_cmd.op = FPS_OP_PROG;
					end else if (is_erall) begin
						next_cmd.op = FPS_OP_ERASE_ALL;
						next_load   = FPS_TW'(ERASE_CYCLES);
					end else begin
						next_cmd.op = FPS_OP_ERASE_BLK;
						next_load   = FPS_TW'(ERASE_CYCLES);
					end
				end
			end
			FPS_PRE: begin
				if (arr_rsp.valid) begin
					if (arr_rsp.rdata != FPS_ERASED) begin
						// Refused if written; all ones counts as unwritten.
						next_st.access_error_flag = 1'b1;
						next_state = FPS_DONE;
					end else begin
						next_cmd.valid = 1'b1;
						next_cmd.op    = FPS_OP_OTP_PROG;
						next_hv        = 1'b1;
						next_tmr       = 1'b1;
						next_state     = FPS_HV;
					end
				end
			end
			FPS_HV: begin
				// At the end of the pulse, read back for verify.
				if (tmr_done) begin
					next_hv        = 1'b0;
					next_cmd.valid = 1'b1;
					next_state     = FPS_VWAIT;
					if (is_prog) begin
						next_cmd.op = FPS_OP_READ;
					end else if (is_otp) begin
						next_cmd.op = FPS_OP_OTP_READ;
					end else if (is_erall) begin
						next_cmd.op = FPS_OP_BLANK_ALL;
					end else begin
						next_cmd.op = FPS_OP_BLANK_BLK;
					end
				end
			end
			FPS_VWAIT: begin
				if (arr_rsp.valid) begin
					next_state = FPS_DONE;
					if (arr_rsp.ecc_err || arr_rsp.ecc_uncorr
						|| arr_rsp.rdata != expect_d) begin
						next_st.verify_error_flag = 1'b1;
					end
					if (arr_rsp.ecc_uncorr) begin
						next_st.verify_uncorrectable_flag = 1'b1;
					end
					// Security opens only on a clean full erase.
					if (is_erall && !next_st.verify_error_flag) begin
						next_sec = 1'b1;
					end
				end
			end
			default: begin
				next_st.command_complete_flag = 1'b1;
				next_state  = FPS_IDLE;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state             <= FPS_IDLE;
			st                <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
			idx               <= 3'h0;
			arr_cmd           <= '0; // No request, operation none.
			arr_hv_en         <= 1'b0;
			security_released <= 1'b0;
		end else begin
			state             <= next_state;
			st                <= next_st;
			idx               <= next_idx;
			arr_cmd           <= next_cmd;
			arr_hv_en         <= next_hv;
			security_released <= next_sec;
		end
	end

	assign flash_status_register = st;
	// Program flash reads are invalid while a one-time command runs past its launch check.
	assign pflash_read_invalid = is_otp && state != FPS_IDLE
		&& state != FPS_CHECK;

	// Times the high-voltage pulse.
	fps_pulse_timer u_timer (
		.mclk  (mclk),
		.rst   (rst),
		.start (next_tmr),
		.load  (next_load),
		.busy  (),
		.done  (tmr_done)
	);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Checks of the sequencer against its intended behaviour.
	AST_LAUNCH_COMPLETE: assert property (
		launch_ok |=> !st.command_complete_flag && state == FPS_CHECK)
		else $error("launch did not clear complete flag");
	AST_IDX_PROG: assert property (
		state == FPS_CHECK && (is_prog || is_otp) && idx != FPS_IX_LAST
		|=> st.access_error_flag && !arr_hv_en) else $error("bad index");
	AST_MISALIGN: assert property (
		state == FPS_CHECK && is_prog && gaddr[2:0] != 3'h0
		|=> st.access_error_flag) else $error("misaligned phrase");
	AST_MODE: assert property (
		state == FPS_CHECK && !mode_allowed[FPS_MB_ERALL] && is_erall
		|=> st.access_error_flag) else $error("mode check missed");
	AST_REJECT: assert property (
		state == FPS_CHECK && (acc_err || pv_err)
		|=> !arr_cmd.valid && !arr_hv_en ##1 st.command_complete_flag)
		else $error("rejected command acted or stalled");
	AST_PROT_ALL: assert property (
		state == FPS_CHECK && is_erall && !acc_err && prot_ee_en
		|=> st.protection_violation_flag && !arr_hv_en)
		else $error("erase all ran on protected memory");
	AST_BUSY_LOW: assert property (
		state inside {FPS_PRE, FPS_HV, FPS_VWAIT}
		|-> !st.command_complete_flag) else $error("complete while busy");
	AST_OTP_READ: assert property (
		is_otp && state inside {FPS_PRE, FPS_HV, FPS_VWAIT}
		|-> pflash_read_invalid) else $error("reads not invalid");
	AST_UNCORR: assert property (
		state == FPS_VWAIT && arr_rsp.valid && arr_rsp.ecc_uncorr
		|=> st.verify_uncorrectable_flag && st.verify_error_flag)
		else $error("uncorrectable error not flagged");
	AST_SECURITY: assert property (
		$rose(security_released) |-> $past(state) == FPS_VWAIT && is_erall)
		else $error("security released outside erase all");
	COV_PROG: cover property (state == FPS_VWAIT && is_prog && arr_rsp.valid
		##1 state == FPS_DONE);
	COV_OTP: cover property (state == FPS_PRE && arr_rsp.valid);
	COV_ERALL: cover property ($rose(security_released));

endmodule

// ### tb/fps_sequencer_bench.sv
// Self-checking testbench of the flash program and erase sequencer.
`timescale 1ns/1ps
module fps_sequencer_bench;
	import fps_pkg::*;

	// One expected outcome per launched command.
	typedef struct packed {
		fps_status_t st;
		logic        sec;
	} fps_bench_exp_t;

	logic           mclk = 1'b0;          // Module clock, 100 MHz.
	logic           rst = 1'b1;           // Synchronous reset.
	logic           cmd_wr = 1'b0;        // Command word write strobe.
	logic [15:0]    cmd_wdata = 16'h0000; // Command word data.
	logic [2:0]     command_word_index = 3'h0;
	logic           launch = 1'b0;        // Clears the complete flag.
	logic [1:0]     err_clear = 2'h0;     // Error flag clear pulses.
	logic [3:0]     mode_allowed = 4'hF;  // Commands allowed in mode.
	logic           prot_pf_en = 1'b0;    // Program flash protection.
	logic [17:0]    prot_pf_base = 18'h3_8000;
	logic [17:0]    prot_pf_limit = 18'h3_8FFF;
	logic           prot_ee_en = 1'b0;    // Data flash protection.
	fps_arr_rsp_t   arr_rsp;              // Array model answer.
	fps_arr_cmd_t   arr_cmd;              // Array request.
	logic           arr_hv_en;            // High-voltage pulse level.
	logic           pflash_read_invalid;  // Reads blocked flag.
	logic           security_released;    // Sticky security release.
	fps_status_t    flash_status_register; // Software status flags.
	int             errors = 0;           // Mismatch counter.
	int             total_checks = 0;     // Comparison counter.
	int             seed = 58;            // Seed of all random values.
	int             nops = 0;             // Array requests seen so far.
	int             cnt = 0;              // Cycles until the answer.
	logic [63:0]    nxt;                  // Data of the pending answer.
	logic [63:0]    vfy_data;             // Read-back after programming.
	logic [63:0]    blank_data;           // Read-back of blank checks.
	logic           ecc_e = 1'b0;         // Correctable fault to report.
	logic           ecc_u = 1'b0;         // Uncorrectable fault to report.
	logic           got_prog = 1'b0;      // A program op was seen.
	logic           sec_now = 1'b0;       // Expected security state.
	logic [17:0]    exp_addr;             // Expected program address.
	logic [63:0]    exp_wdata;            // Expected program data.
	logic           prev_cc = 1'b1;       // Complete flag last cycle.
	logic [63:0]    d;                    // Random phrase data.
	fps_bench_exp_t expq[$];              // Outcomes still awaited.
	logic [7:0]     codes [4] = '{FPS_CMD_PROG, FPS_CMD_OTP,
		FPS_CMD_ERALL, FPS_CMD_ERBLK};
	logic [2:0]     ixs [4] = '{FPS_IX_LAST, FPS_IX_LAST,
		FPS_IX_ERALL, FPS_IX_ERBLK};

	// Device under test with a short erase pulse.
	fps_sequencer #(.ERASE_CYCLES(20)) DUT (
		.mclk                  (mclk),
		.rst                   (rst),
		.cmd_wr                (cmd_wr),
		.cmd_wdata             (cmd_wdata),
		.command_word_index    (command_word_index),
		.launch                (launch),
		.err_clear             (err_clear),
		.mode_allowed          (mode_allowed),
		.prot_pf_en            (prot_pf_en),
		.prot_pf_base          (prot_pf_base),
		.prot_pf_limit         (prot_pf_limit),
		.prot_ee_en            (prot_ee_en),
		.arr_rsp               (arr_rsp),
		.arr_cmd               (arr_cmd),
		.arr_hv_en             (arr_hv_en),
		.pflash_read_invalid   (pflash_read_invalid),
		.security_released     (security_released),
		.flash_status_register (flash_status_register)
	);

	// Clock of 10 ns period.
	always #5 mclk = ~mclk;

	// Counts one comparison and reports it when it differs.
	task automatic chk(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Writes one command word while the sequencer is idle.
	task automatic wr(input logic [2:0] ix, input logic [15:0] v);
		@(negedge mclk);
		cmd_wr = 1'b1;
		command_word_index = ix;
		cmd_wdata = v;
		@(negedge mclk);
		cmd_wr = 1'b0;
	endtask

	// Loads, launches and awaits one command; fl is acc, pv, ve, vu.
	task automatic run(input logic [7:0] code, input logic [1:0] blk,
		input logic [15:0] w1, input logic [2:0] ix,
		input logic [3:0] fl, input logic rej);
		int             k;
		int             n0;
		fps_bench_exp_t e;
		wr(3'h0, {code, 6'h00, blk});
		wr(3'h1, w1);
		for (int i = 0; i < 4; i++) begin
			wr(3'(i + 2), d[16*i +: 16]);
		end
		@(negedge mclk);
		command_word_index = ix;
		got_prog = 1'b0;
		exp_addr = {blk, w1};
		exp_wdata = d;
		e.st = fps_status_t'({1'b1, fl});
		e.sec = sec_now;
		expq.push_back(e);
		n0 = nops;
		launch = 1'b1;
		@(negedge mclk);
		launch = 1'b0;
		@(negedge mclk);
		k = 0;
		// No word is written until the command has completed.
		while (flash_status_register.command_complete_flag !== 1'b1 &&
			k < 3000) begin
			@(negedge mclk);
			k++;
		end
		if (k >= 3000) begin
			errors++;
			results();
		end
		if (rej) begin
			chk("reject_cycles", 64'(k <= 3), 64'h1);
			chk("reject_ops", 64'(nops - n0), 64'h0);
		end
		@(negedge mclk);
		err_clear = 2'h3;
		@(negedge mclk);
		err_clear = 2'h0;
	endtask

	// Compares the flags each time the complete flag rises.
	always @(posedge mclk) begin
		fps_bench_exp_t e;
		if (!rst && prev_cc === 1'b0 &&
			flash_status_register.command_complete_flag === 1'b1) begin
			if (expq.size() == 0) begin
				chk("unexpected_complete", 64'h1, 64'h0);
			end else begin
				e = expq.pop_front();
				chk("status", 64'(flash_status_register), 64'(e.st));
				chk("security", 64'(security_released), 64'(e.sec));
			end
		end
		prev_cc <= flash_status_register.command_complete_flag;
	end

	// Array model: checks requests and answers each read once.
	always @(negedge mclk) begin
		arr_rsp.valid = 1'b0;
		arr_rsp.rdata = ~arr_rsp.rdata;
		if (cnt > 0) begin
			cnt--;
			if (cnt == 0) begin
				arr_rsp = '{1'b1, nxt, ecc_e | ecc_u, ecc_u};
			end
		end
		if (arr_cmd.valid === 1'b1) begin
			nops++;
			case (arr_cmd.op)
				FPS_OP_PROG: begin
					got_prog = 1'b1;
					chk("prog_addr", 64'(arr_cmd.addr), 64'(exp_addr));
					chk("prog_data", arr_cmd.wdata, exp_wdata);
					chk("read_valid", 64'(pflash_read_invalid), 64'h0);
					chk("hv_on", 64'(arr_hv_en), 64'h1);
				end
				FPS_OP_OTP_PROG: begin
					got_prog = 1'b1;
					chk("otp_data", arr_cmd.wdata, exp_wdata);
					chk("read_invalid", 64'(pflash_read_invalid), 64'h1);
					chk("hv_otp", 64'(arr_hv_en), 64'h1);
				end
				FPS_OP_ERASE_BLK, FPS_OP_ERASE_ALL: begin
					chk("hv_erase", 64'(arr_hv_en), 64'h1);
				end
				FPS_OP_READ, FPS_OP_OTP_READ, FPS_OP_BLANK_BLK,
				FPS_OP_BLANK_ALL: begin
					chk("hv_off", 64'(arr_hv_en), 64'h0);
					nxt = got_prog ? vfy_data : blank_data;
					cnt = 1 + ($random(seed) & 3);
				end
				default: begin
				end
			endcase
		end
	end

	// Main sequence of scenarios.
	initial begin
		arr_rsp = '0;
		blank_data = FPS_ERASED;
		d = {$random(seed), $random(seed)};
		vfy_data = d;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		run(FPS_CMD_PROG, 2'h3, 16'h0010, 3'h5, 4'h0, 1'b0);
		run(FPS_CMD_PROG, 2'h3, 16'h0013, 3'h5, 4'h8, 1'b1);
		run(FPS_CMD_PROG, 2'h3, 16'h0010, 3'h4, 4'h8, 1'b1);
		run(FPS_CMD_PROG, 2'h0, 16'h0010, 3'h5, 4'h8, 1'b1);
		prot_pf_en = 1'b1;
		run(FPS_CMD_PROG, 2'h3, 16'h8100, 3'h5, 4'h4, 1'b1);
		prot_pf_en = 1'b0;
		vfy_data = ~d;
		run(FPS_CMD_PROG, 2'h3, 16'h0020, 3'h5, 4'h2, 1'b0);
		vfy_data = d;
		ecc_u = 1'b1;
		run(FPS_CMD_PROG, 2'h3, 16'h0028, 3'h5, 4'h3, 1'b0);
		ecc_u = 1'b0;
		for (int m = 0; m < 4; m++) begin
			mode_allowed = ~(4'h1 << m);
			run(codes[m], 2'h3, 16'h0000, ixs[m], 4'h8, 1'b1);
		end
		mode_allowed = 4'hF;
		d = {$random(seed), $random(seed)};
		vfy_data = d;
		run(FPS_CMD_OTP, 2'h0, 16'h0007, 3'h5, 4'h0, 1'b0);
		run(FPS_CMD_OTP, 2'h0, 16'h0008, 3'h5, 4'h8, 1'b1);
		run(FPS_CMD_OTP, 2'h0, 16'h0003, 3'h4, 4'h8, 1'b1);
		blank_data = d;
		run(FPS_CMD_OTP, 2'h0, 16'h0003, 3'h5, 4'h8, 1'b0);
		blank_data = FPS_ERASED;
		run(FPS_CMD_ERALL, 2'h0, 16'h0000, 3'h1, 4'h8, 1'b1);
		prot_ee_en = 1'b1;
		run(FPS_CMD_ERALL, 2'h0, 16'h0000, 3'h0, 4'h4, 1'b1);
		prot_ee_en = 1'b0;
		blank_data = ~FPS_ERASED;
		run(FPS_CMD_ERALL, 2'h0, 16'h0000, 3'h0, 4'h2, 1'b0);
		blank_data = FPS_ERASED;
		sec_now = 1'b1;
		run(FPS_CMD_ERALL, 2'h0, 16'h0000, 3'h0, 4'h0, 1'b0);
		run(FPS_CMD_ERBLK, 2'h0, 16'h0010, 3'h1, 4'h0, 1'b0);
		run(FPS_CMD_ERBLK, 2'h3, 16'h0000, 3'h0, 4'h8, 1'b1);
		run(FPS_CMD_ERBLK, 2'h1, 16'h0000, 3'h1, 4'h8, 1'b1);
		run(FPS_CMD_ERBLK, 2'h2, 16'h0000, 3'h1, 4'h8, 1'b1);
		run(FPS_CMD_ERBLK, 2'h3, 16'h0004, 3'h1, 4'h8, 1'b1);
		run(FPS_CMD_ERBLK, 2'h0, 16'h0001, 3'h1, 4'h8, 1'b1);
		prot_pf_en = 1'b1;
		run(FPS_CMD_ERBLK, 2'h3, 16'h0000, 3'h1, 4'h4, 1'b1);
		prot_pf_en = 1'b0;
		run(8'h05, 2'h3, 16'h0000, 3'h5, 4'h8, 1'b1);
		chk("pending", 64'(expq.size()), 64'h0);
		results();
	end

endmodule
